// file: uirq_pkg.sv
// shared constants for the uart interrupt level and mask slice
`default_nettype none
package uirq_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UIRQ_OFS_TRIG = 8'h34; // fifo_irq_trigger_level
    localparam logic [7:0] UIRQ_OFS_MASK = 8'h38; // irq_enable_mask
    localparam logic [7:0] UIRQ_OFS_RAW = 8'h3c; // raw status, read only
    localparam logic [7:0] UIRQ_OFS_MSKD = 8'h40; // masked status, read only
    localparam logic [7:0] UIRQ_OFS_CLR = 8'h44; // clear, write only
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int UIRQ_NSRC = 13; // source bits 12..0
    localparam int UIRQ_TX_LSB = 0; // tx_trigger_select 2:0
    localparam int UIRQ_RX_LSB = 3; // rx_trigger_select 5:3
    localparam int UIRQ_SEL_W = 3;
    localparam int UIRQ_TRIG_W = 6;
    localparam int UIRQ_CTS_BIT = 1;
    localparam int UIRQ_RX_BIT = 4;
    localparam int UIRQ_TX_BIT = 5;
    localparam int UIRQ_RT_BIT = 6;
    localparam int UIRQ_FE_BIT = 7;
    localparam int UIRQ_PE_BIT = 8;
    localparam int UIRQ_BE_BIT = 9;
    localparam int UIRQ_OE_BIT = 10;
    localparam int UIRQ_XOFF_BIT = 11;
    localparam int UIRQ_TXFE_BIT = 12;
    // implemented source bits; 0, 2, 3 are reserved
    localparam logic [12:0] UIRQ_SRC_BITS = 13'h1ff2;
    // ------------------------------------------------------------
    // reset values and trigger codes
    // ------------------------------------------------------------
    localparam logic [2:0] UIRQ_SEL_RST = 3'h2; // one sixteenth
    localparam logic [12:0] UIRQ_MASK_RST = 13'h0000;
    localparam logic [2:0] UIRQ_SEL_64 = 3'h0;
    localparam logic [2:0] UIRQ_SEL_32 = 3'h1;
    localparam logic [2:0] UIRQ_SEL_16 = 3'h2;
    localparam logic [2:0] UIRQ_SEL_8 = 3'h3;
    localparam logic [2:0] UIRQ_SEL_4 = 3'h4;
    localparam logic [2:0] UIRQ_SEL_2 = 3'h5;
    localparam logic [2:0] UIRQ_SEL_34 = 3'h6;
    // ------------------------------------------------------------
    // axi4-lite response codes
    // ------------------------------------------------------------
    localparam logic [1:0] UIRQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] UIRQ_RESP_SLVERR = 2'h2;
endpackage : uirq_pkg
`default_nettype wire

// file: uirq_level_cmp.sv
// fifo fill level against a selected fraction of the fifo depth
`default_nettype none
module uirq_level_cmp
    import uirq_pkg::*;
#(
    parameter int DEPTH = 64, // fifo entries
    parameter int LVL_W = 7 // width of the fill count
) (
    // ---- configuration ----
    input wire logic [2:0] sel_i, // trigger select code
    input wire logic count_empty_i, // 1: compare free space, 0: fill
    // ---- fifo state ----
    input wire logic [LVL_W-1:0] level_i, // entries in use
    // ---- result ----
    output logic hit_o // threshold reached
);
    logic [LVL_W-1:0] amount; // free or used entries
    logic [LVL_W-1:0] thr; // entries needed

    // ------------------------------------------------------------
    // threshold select; 111 behaves as the largest defined step
    // ------------------------------------------------------------
    always_comb begin
        amount = count_empty_i ? LVL_W'(DEPTH) - level_i : level_i;
        case (sel_i)
            UIRQ_SEL_64: thr = LVL_W'(DEPTH / 64);
            UIRQ_SEL_32: thr = LVL_W'(DEPTH / 32);
            UIRQ_SEL_16: thr = LVL_W'(DEPTH / 16);
            UIRQ_SEL_8: thr = LVL_W'(DEPTH / 8);
            UIRQ_SEL_4: thr = LVL_W'(DEPTH / 4);
            UIRQ_SEL_2: thr = LVL_W'(DEPTH / 2);
            UIRQ_SEL_34: thr = LVL_W'((DEPTH * 3) / 4);
            default: thr = LVL_W'((DEPTH * 3) / 4);
        endcase
        hit_o = (amount >= thr);
    end
endmodule : uirq_level_cmp
`default_nettype wire

// file: uirq_flag.sv
// one sticky interrupt status bit, set wins over clear
`default_nettype none
module uirq_flag (
    // ---- clock and reset ----
    input wire logic mclk_i, // bus clock
    input wire logic rst_n_i, // synchronous, active low
    // ---- control ----
    input wire logic set_i, // event
    input wire logic clr_i, // write one to clear
    // ---- state ----
    output logic flag_o // pending
);
    logic flag_reg;
    logic flag_next;

    // ------------------------------------------------------------
    // event in the clearing cycle is kept
    // ------------------------------------------------------------
    always_comb begin
        flag_next = set_i | (flag_reg & ~clr_i);
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;
endmodule : uirq_flag
`default_nettype wire

// file: uirq_ctrl.sv
// uart interrupt trigger level and enable mask with axi4-lite access
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module uirq_ctrl
    import uirq_pkg::*;
#(
    parameter int TX_DEPTH = 64, // transmit fifo entries
    parameter int RX_DEPTH = 64, // receive fifo entries
    parameter int LVL_W = 7 // fill count width
) (
    // ---- clock and reset ----
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // ---- axi4-lite write address ----
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // ---- axi4-lite write data ----
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // ---- axi4-lite write response ----
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // ---- axi4-lite read address ----
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // ---- axi4-lite read data ----
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // ---- uart core events and fifo levels ----
    input wire logic [12:0] event_i, // one-cycle pulses, same clock
    input wire logic [LVL_W-1:0] tx_level_i, // tx entries in use
    input wire logic [LVL_W-1:0] rx_level_i, // rx entries in use
    // ---- towards the uart core ----
    output logic [2:0] tx_trigger_select_o,
    output logic [2:0] rx_trigger_select_o,
    output logic [12:0] irq_enable_mask_o,
    output logic [12:0] masked_status_o,
    output logic [12:0] clear_strobe_o, // one-cycle clear pulses
    output logic irq_o // level interrupt
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tx_sel; // transmit trigger select
        logic [2:0] rx_sel; // receive trigger select
        logic [12:0] mask; // enable mask
        logic [7:0] awaddr; // held write address
        logic aw_held; // write address captured
        logic awrdy;
        logic [31:0] wdata; // held write data
        logic [3:0] wstrb;
        logic w_held; // write data captured
        logic wrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [12:0] mskd; // masked status copy
        logic [12:0] clr; // clear pulses
        logic irq;
    } uirq_state_s;

    uirq_state_s st_reg;
    uirq_state_s st_next;

    logic [12:0] raw; // sticky raw status
    logic [12:0] set_vec; // hardware set terms
    logic [12:0] clr_vec; // software clear terms
    logic tx_hit; // tx fifo threshold reached
    logic rx_hit; // rx fifo threshold reached
    logic wr_go; // write both halves present
    logic [7:0] wa; // aligned write address
    logic [7:0] ra; // aligned read address

    // ------------------------------------------------------------
    // fifo level comparators
    // ------------------------------------------------------------
    // one comparator per fifo; tx counts free entries, rx counts used ones
    uirq_level_cmp #(
        .DEPTH(TX_DEPTH),
        .LVL_W(LVL_W)
    ) u_tx_cmp (
        .sel_i(st_reg.tx_sel),
        .count_empty_i(1'b1),
        .level_i(tx_level_i),
        .hit_o(tx_hit)
    );

    uirq_level_cmp #(
        .DEPTH(RX_DEPTH),
        .LVL_W(LVL_W)
    ) u_rx_cmp (
        .sel_i(st_reg.rx_sel),
        .count_empty_i(1'b0),
        .level_i(rx_level_i),
        .hit_o(rx_hit)
    );

    // ------------------------------------------------------------
    // event sources; fifo thresholds join the rx and tx bits
    // ------------------------------------------------------------
    always_comb begin
        set_vec = event_i & UIRQ_SRC_BITS;
        set_vec[UIRQ_RX_BIT] = event_i[UIRQ_RX_BIT] | rx_hit;
        set_vec[UIRQ_TX_BIT] = event_i[UIRQ_TX_BIT] | tx_hit;
    end

    // ------------------------------------------------------------
    // sticky status, one flag per source
    // ------------------------------------------------------------
    // set wins over clear inside each flag, so an event is never lost
    // when software clears the same source in the same cycle
    for (genvar i = 0; i < UIRQ_NSRC; i++) begin : g_flag
        uirq_flag u_flag (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .set_i(set_vec[i]),
            .clr_i(clr_vec[i]),
            .flag_o(raw[i])
        );
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // low two address bits ignored; every register is one aligned word
    // the write decodes the held address, the read the live one, since a
    // read is answered in the cycle right after it is taken
    assign wa = {st_reg.awaddr[7:2], 2'b00};
    assign ra = {s_axi_araddr[7:2], 2'b00};
    assign wr_go = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    // clear register hit with low byte lanes; zeros do nothing
    always_comb begin
        clr_vec = '0;
        if (wr_go && wa == UIRQ_OFS_CLR) begin
            clr_vec[7:0] = st_reg.wstrb[0] ? st_reg.wdata[7:0] : 8'h00;
            clr_vec[12:8] = st_reg.wstrb[1] ? st_reg.wdata[12:8] : 5'h00;
            clr_vec = clr_vec & UIRQ_SRC_BITS;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.clr = clr_vec;
        // write address channel, taken in any order with data
        if (s_axi_awvalid && st_reg.awrdy) begin
            st_next.awaddr = s_axi_awaddr;
            st_next.aw_held = 1'b1;
        end
        // write data channel
        if (s_axi_wvalid && st_reg.wrdy) begin
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
            st_next.w_held = 1'b1;
        end
        // response retires first so a new write may start
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        // a pending response blocks the next write, so one is in flight at most
        if (wr_go) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = UIRQ_RESP_OKAY;
            case (wa)
                UIRQ_OFS_TRIG: begin
                    // only the low six bits exist
                    if (st_reg.wstrb[0]) begin
                        st_next.tx_sel = st_reg.wdata[UIRQ_TX_LSB +: UIRQ_SEL_W];
                        st_next.rx_sel = st_reg.wdata[UIRQ_RX_LSB +: UIRQ_SEL_W];
                    end
                end
                UIRQ_OFS_MASK: begin
                    // reserved bits stay zero whatever is written
                    if (st_reg.wstrb[0]) begin
                        st_next.mask[7:0] = st_reg.wdata[7:0] & UIRQ_SRC_BITS[7:0];
                    end
                    if (st_reg.wstrb[1]) begin
                        st_next.mask[12:8] = st_reg.wdata[12:8];
                    end
                end
                UIRQ_OFS_RAW, UIRQ_OFS_MSKD, UIRQ_OFS_CLR: begin
                    // read-only status ignores writes; clear works above
                    st_next.bresp = UIRQ_RESP_OKAY;
                end
                default: begin
                    // unmapped offset
                    st_next.bresp = UIRQ_RESP_SLVERR;
                end
            endcase
        end
        // ready flags registered; low while a half is held
        st_next.awrdy = ~st_next.aw_held;
        st_next.wrdy = ~st_next.w_held;
        // arready drops while read data wait, so one read is in flight at most
        // read channel
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arrdy) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = UIRQ_RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (ra)
                UIRQ_OFS_TRIG: begin
                    st_next.rdata[UIRQ_TX_LSB +: UIRQ_SEL_W] = st_reg.tx_sel;
                    st_next.rdata[UIRQ_RX_LSB +: UIRQ_SEL_W] = st_reg.rx_sel;
                end
                UIRQ_OFS_MASK: begin
                    // plain read of the live mask, nothing changes
                    st_next.rdata[12:0] = st_reg.mask;
                end
                UIRQ_OFS_RAW: begin
                    st_next.rdata[12:0] = raw;
                end
                UIRQ_OFS_MSKD: begin
                    st_next.rdata[12:0] = raw & st_reg.mask;
                end
                UIRQ_OFS_CLR: begin
                    // write-only register reads as zero
                    st_next.rresp = UIRQ_RESP_OKAY;
                end
                default: begin
                    st_next.rresp = UIRQ_RESP_SLVERR;
                end
            endcase
        end
        st_next.arrdy = ~st_next.rvalid;
        // masked status: bit 1 cts, 4 rx, 5 tx, 6 timeout, 7..10 errors,
        // 11 xoff, 12 tx empty; registered so outputs come from flops
        st_next.mskd = raw & st_reg.mask;
        st_next.irq = |(raw & st_reg.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset; ready flags come up high so the first request
    // may be offered in the cycle right after release
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.tx_sel <= UIRQ_SEL_RST;
            st_reg.rx_sel <= UIRQ_SEL_RST;
            st_reg.mask <= UIRQ_MASK_RST;
            st_reg.awrdy <= 1'b1;
            st_reg.wrdy <= 1'b1;
            st_reg.arrdy <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------
    // status copy and irq lag the raw flags by one cycle; a software read
    // of the masked register sees the live product instead
    assign s_axi_awready = st_reg.awrdy;
    assign s_axi_wready = st_reg.wrdy;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arrdy;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign tx_trigger_select_o = st_reg.tx_sel;
    assign rx_trigger_select_o = st_reg.rx_sel;
    assign irq_enable_mask_o = st_reg.mask;
    assign masked_status_o = st_reg.mskd;
    assign clear_strobe_o = st_reg.clr;
    assign irq_o = st_reg.irq;
endmodule : uirq_ctrl
`default_nettype wire

// file: uirq_ctrl_assertions.sv
// concurrent checks on the ports of the interrupt level and mask slice
`default_nettype none
module uirq_ctrl_assertions
    import uirq_pkg::*;
(
    // ---- clock and reset ----
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // ---- register bus ----
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // ---- uart core side ----
    input wire logic [12:0] event_i,
    input wire logic [2:0] tx_trigger_select_o,
    input wire logic [2:0] rx_trigger_select_o,
    input wire logic [12:0] irq_enable_mask_o,
    input wire logic [12:0] masked_status_o,
    input wire logic [12:0] clear_strobe_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // properties, all in the bus clock domain
    // ------------------------------------------------------------
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_sel_reset: assert property ($rose(rst_n_i) |->
        tx_trigger_select_o == UIRQ_SEL_RST && rx_trigger_select_o == UIRQ_SEL_RST
        && irq_enable_mask_o == UIRQ_MASK_RST) else $error("reset values wrong");
    // irq and masked status come from the same registered product
    chk_irq_level: assert property (irq_o == (masked_status_o != 13'h0))
        else $error("irq level disagrees with masked status");
    chk_masked_gate: assert property (
        (masked_status_o & ~$past(irq_enable_mask_o)) == 13'h0)
        else $error("masked status set under a disabled source");
    chk_event_irq: assert property (
        (event_i & irq_enable_mask_o & UIRQ_SRC_BITS) != 13'h0 ##1 $stable(irq_enable_mask_o)
        |-> ##[1:2] irq_o) else $error("enabled event raised no interrupt");
    chk_reserved_zero: assert property (
        ((irq_enable_mask_o | masked_status_o | clear_strobe_o) & ~UIRQ_SRC_BITS) == 13'h0)
        else $error("reserved bit active");
    chk_clear_pulse: assert property (clear_strobe_o != 13'h0 |=> clear_strobe_o == 13'h0)
        else $error("clear strobe longer than one cycle");
    chk_mask_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == UIRQ_OFS_MASK
        |=> s_axi_rdata == {19'h0, $past(irq_enable_mask_o)}) else $error("mask read wrong");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // both halves taken at one edge: performed next cycle, response the edge after
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write answer late");
endmodule : uirq_ctrl_assertions

bind uirq_ctrl uirq_ctrl_assertions i_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .event_i(event_i), .tx_trigger_select_o(tx_trigger_select_o),
    .rx_trigger_select_o(rx_trigger_select_o), .irq_enable_mask_o(irq_enable_mask_o),
    .masked_status_o(masked_status_o), .clear_strobe_o(clear_strobe_o), .irq_o(irq_o));
`default_nettype wire

// file: uirq_ctrl_bench.sv
// self-checking bench for the interrupt level and mask slice
`default_nettype none
module uirq_ctrl_bench;
    import uirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    localparam int DEPTH = 64; // both fifos
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0; // held low for the first eight edges
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [12:0] ev = 13'h0; // event pulses
    logic [6:0] txl = 7'h0, rxl = 7'h0; // fifo fill counts
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] txsel, rxsel;
    logic [12:0] mask, mskd, clrs;
    int num_errors = 0, checks_done = 0, cycles = 0;

    uirq_ctrl #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH), .LVL_W(7)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_i(ev),
        .tx_level_i(txl), .rx_level_i(rxl), .tx_trigger_select_o(txsel),
        .rx_trigger_select_o(rxsel), .irq_enable_mask_o(mask), .masked_status_o(mskd),
        .clear_strobe_o(clrs), .irq_o(irq));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // a hung handshake ends here rather than running forever
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        // bready stays high so a following write never drops and raises it at one edge
        check({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        // rready stays high for the next read, no double drive at one edge
        d = rdata;
        check({30'h0, rresp}, {30'h0, er});
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, UIRQ_RESP_OKAY);
        check(d & m, e);
    endtask : rchk

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int thr;
        logic [31:0] bk, ek, d;
        tick(8);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rchk(UIRQ_OFS_TRIG, 32'hffffffff, 32'h12);
        rchk(UIRQ_OFS_MASK, 32'hffffffff, 32'h0);
        check({26'h0, rxsel, txsel}, 32'h12);
        // every legal code on both selectors, below and at its threshold; 111 never written
        for (int c = 0; c < 7; c++) begin
            wr(UIRQ_OFS_TRIG, {26'h3ffffff, 3'(c), 3'(c)}, UIRQ_RESP_OKAY);
            rchk(UIRQ_OFS_TRIG, 32'hffffffff, {26'h0, 3'(c), 3'(c)});
            thr = (c == 6) ? DEPTH * 3 / 4 : DEPTH >> (6 - c);
            txl <= 7'(DEPTH - thr + 1);
            rxl <= 7'(thr - 1);
            tick(2);
            wr(UIRQ_OFS_CLR, 32'h30, UIRQ_RESP_OKAY);
            rchk(UIRQ_OFS_RAW, 32'h30, 32'h0);
            txl <= 7'(DEPTH - thr);
            rxl <= 7'(thr);
            tick(2);
            rchk(UIRQ_OFS_RAW, 32'h30, 32'h30);
        end
        // quiet fifos: tx full, rx empty
        txl <= 7'(DEPTH);
        rxl <= 7'h0;
        tick(2);
        wr(UIRQ_OFS_CLR, 32'hffffffff, UIRQ_RESP_OKAY);
        wr(UIRQ_OFS_MASK, 32'hffffffff, UIRQ_RESP_OKAY);
        rchk(UIRQ_OFS_MASK, 32'hffffffff, 32'h1ff2);
        rchk(UIRQ_OFS_MASK, 32'hffffffff, 32'h1ff2);
        check({19'h0, mask}, 32'h1ff2);
        // each source alone: disabled, enabled, cleared; reserved ones stay dead
        for (int k = 0; k < 13; k++) begin
            bk = 32'h1 << k;
            ek = UIRQ_SRC_BITS[k] ? bk : 32'h0;
            wr(UIRQ_OFS_MASK, 32'h0, UIRQ_RESP_OKAY);
            ev <= bk[12:0];
            @(posedge mclk_i);
            ev <= 13'h0;
            tick(2);
            rchk(UIRQ_OFS_RAW, 32'hffffffff, ek);
            check({31'h0, irq}, 32'h0);
            wr(UIRQ_OFS_MASK, bk, UIRQ_RESP_OKAY);
            tick(2);
            rchk(UIRQ_OFS_MSKD, 32'hffffffff, ek);
            check({31'h0, irq}, {31'h0, ek != 32'h0});
            check({19'h0, mskd}, ek);
            ev <= bk[12:0];
            @(posedge mclk_i);
            ev <= 13'h0;
            wr(UIRQ_OFS_CLR, ~bk, UIRQ_RESP_OKAY);
            check({19'h0, clrs}, {19'h0, ~bk[12:0] & UIRQ_SRC_BITS});
            rchk(UIRQ_OFS_RAW, 32'hffffffff, ek);
            wr(UIRQ_OFS_CLR, bk, UIRQ_RESP_OKAY);
            check({19'h0, clrs}, ek);
            tick(2);
            check({31'h0, irq}, 32'h0);
            rchk(UIRQ_OFS_RAW, 32'hffffffff, 32'h0);
        end
        // unmapped place and the write-only clear register
        wr(8'h80, 32'hffffffff, UIRQ_RESP_SLVERR);
        rd(8'h80, d, UIRQ_RESP_SLVERR);
        check(d, 32'h0);
        rchk(UIRQ_OFS_CLR, 32'hffffffff, 32'h0);
        // second reset in mid-run restores the defaults
        wr(UIRQ_OFS_MASK, 32'h1ff2, UIRQ_RESP_OKAY);
        wr(UIRQ_OFS_TRIG, 32'h0, UIRQ_RESP_OKAY);
        rst_n_i <= 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rchk(UIRQ_OFS_TRIG, 32'hffffffff, 32'h12);
        rchk(UIRQ_OFS_MASK, 32'hffffffff, 32'h0);
        summarize();
    end
endmodule : uirq_ctrl_bench
`default_nettype wire
